// File: logic/sows_pkg.sv
package sows_pkg;

  // Power states, one-hot
  typedef enum logic [3:0] {
    SOWS_ST_RUN     = 4'h1,
    SOWS_ST_SUSPEND = 4'h2,
    SOWS_ST_STBYOFF = 4'h4,
    SOWS_ST_MECHOFF = 4'h8
  } sows_state_t;

  localparam int unsigned SYS_CLK_HZ      = 200000000;
  // Forced-off hold time, seconds
  localparam int unsigned HOLD_OFF_S      = 4;
  // Blink half period, milliseconds
  localparam int unsigned BLINK_HALF_MS   = 500;
  // Debounce time, microseconds
  localparam int unsigned DEBOUNCE_US     = 10000;
  // Slow tick: 1 kHz enable
  localparam int unsigned TICK_HZ         = 1000;
  localparam int unsigned TICK_DIV        = SYS_CLK_HZ / TICK_HZ;
  localparam int unsigned HOLD_OFF_TICKS  = HOLD_OFF_S * TICK_HZ;
  localparam int unsigned BLINK_TICKS     = BLINK_HALF_MS * TICK_HZ / 1000;
  localparam int unsigned DEBOUNCE_TICKS  = (DEBOUNCE_US * (TICK_HZ / 1000) + 999) / 1000;
  localparam int unsigned TICK_W          = 18;
  localparam int unsigned CNT_W           = 16;
  localparam int unsigned ALARM_W         = 32;
  localparam int unsigned WAKE_SRC_N      = 4;
  // Wake cause bit positions
  localparam int unsigned WK_BUTTON       = 0;
  localparam int unsigned WK_RING         = 1;
  localparam int unsigned WK_ALARM        = 2;
  localparam int unsigned WK_NET          = 3;

endpackage

// File: logic/sows_sync_edge.sv
`timescale 1ns/1ps
module sows_sync_edge (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic async_in,
  output logic      level_out,
  output logic      rise_out
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // Second stage is the only reader of the first
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign level_out = sync_reg;
  assign rise_out  = sync_reg & ~last_reg;
endmodule

// File: logic/sows_sequencer.sv
`timescale 1ns/1ps
// Overview of operation
// - Suspend makes the power LED blink slowly
// - Keypress wakes suspend; LED then steady on
// - Button acts as suspend with standby supply
// - Button press while running enters standby-off when atx_present is high
// - Standby-off suspends display, spins disks down
// - Button press in standby-off wakes to running
// - Four second hold cuts supply completely
// - Modem ring wakes from standby-off
// - Programmable clock alarm wakes the system
// - Network wake header powers up off system
// - Events reported on SMI or SCI outputs
module sows_sequencer
  import sows_pkg::*;
  // Cycles per slow tick; a shorter tick lets a bench reach the long timers
#(parameter int unsigned TICK_CYCLES = TICK_DIV)
(
  input  wire logic               sys_clk,
  input  wire logic               reset,
  input  wire logic               atx_present,
  input  wire logic               power_button,
  input  wire logic               keypress,
  input  wire logic               modem_ring,
  input  wire logic               remote_network_wake,
  input  wire logic               suspend_request,
  input  wire logic               sci_mode,
  input  wire logic               alarm_enable,
  input  wire logic [ALARM_W-1:0] alarm_time,
  input  wire logic [ALARM_W-1:0] rtc_time,
  input  wire logic               event_ack,
  output logic                    power_led,
  output logic                    supply_on,
  output logic                    display_suspend,
  output logic                    disk_spin_down,
  output logic                    cpu_running,
  output logic                    smi_out,
  output logic                    sci_out,
  output logic [WAKE_SRC_N-1:0]   wake_cause,
  output logic [3:0]              power_state
);

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic btn_lvl;
  logic key_rise;
  logic ring_rise;
  logic net_rise;
  logic susp_rise;

  sows_sync_edge u_btn (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .async_in  (power_button),
    .level_out (btn_lvl),
    .rise_out  ()
  );

  sows_sync_edge u_key (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .async_in  (keypress),
    .level_out (),
    .rise_out  (key_rise)
  );

  sows_sync_edge u_ring (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .async_in  (modem_ring),
    .level_out (),
    .rise_out  (ring_rise)
  );

  sows_sync_edge u_net (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .async_in  (remote_network_wake),
    .level_out (),
    .rise_out  (net_rise)
  );

  sows_sync_edge u_susp (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .async_in  (suspend_request),
    .level_out (),
    .rise_out  (susp_rise)
  );

  ////////////////////////////////////////////////////////////////////////
  // Slow tick divider

  logic [TICK_W-1:0] div_reg;
  logic              tick;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      div_reg <= '0;
    end else if (div_reg == TICK_W'(TICK_CYCLES - 1)) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  assign tick = (div_reg == TICK_W'(TICK_CYCLES - 1));

  ////////////////////////////////////////////////////////////////////////
  // Button debounce and hold timing

  logic [CNT_W-1:0] deb_reg;
  logic             btn_reg;
  logic [CNT_W-1:0] hold_reg;
  logic             hold_fired_reg;
  logic             btn_release;
  logic             long_hold;

  // Glitches no longer than nine slow ticks never change the state
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      deb_reg <= '0;
      btn_reg <= 1'b0;
    end else if (btn_lvl == btn_reg) begin
      deb_reg <= '0;
    end else if (tick) begin
      if (deb_reg == CNT_W'(DEBOUNCE_TICKS - 1)) begin
        deb_reg <= '0;
        btn_reg <= btn_lvl;
      end else begin
        deb_reg <= deb_reg + 1'b1;
      end
    end
  end

  // Hold counter on the slow tick
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      hold_reg <= '0;
    end else if (!btn_reg) begin
      hold_reg <= '0;
    end else if (tick && hold_reg != CNT_W'(HOLD_OFF_TICKS)) begin
      hold_reg <= hold_reg + 1'b1;
    end
  end

  assign long_hold = btn_reg && (hold_reg == CNT_W'(HOLD_OFF_TICKS)) && !hold_fired_reg;

  // Remember a fired hold so the release is not a toggle
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      hold_fired_reg <= 1'b0;
    end else if (long_hold) begin
      hold_fired_reg <= 1'b1;
    end else if (!btn_reg) begin
      hold_fired_reg <= 1'b0;
    end
  end

  logic btn_last_reg;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      btn_last_reg <= 1'b0;
    end else begin
      btn_last_reg <= btn_reg;
    end
  end

  // Acting on release lets a long hold be told apart from a press
  assign btn_release = btn_last_reg && !btn_reg && !hold_fired_reg;

  ////////////////////////////////////////////////////////////////////////
  // Alarm compare

  logic alarm_hit;

  assign alarm_hit = alarm_enable && (rtc_time == alarm_time);

  ////////////////////////////////////////////////////////////////////////
  // Power state machine

  sows_state_t state_reg;
  sows_state_t state_next;
  logic        off_wake;

  assign off_wake = ring_rise || net_rise || alarm_hit;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SOWS_ST_RUN: begin
        if (long_hold) begin
          state_next = SOWS_ST_MECHOFF;
        end else if (btn_release && atx_present) begin
          state_next = SOWS_ST_STBYOFF;
        end else if (btn_release) begin
          // Without standby power the button is a plain cut-off
          state_next = SOWS_ST_MECHOFF;
        end else if (susp_rise) begin
          state_next = SOWS_ST_SUSPEND;
        end
      end
      SOWS_ST_SUSPEND: begin
        if (long_hold) begin
          state_next = SOWS_ST_MECHOFF;
        end else if (key_rise || btn_release || off_wake) begin
          state_next = SOWS_ST_RUN;
        end
      end
      SOWS_ST_STBYOFF: begin
        if (long_hold) begin
          state_next = SOWS_ST_MECHOFF;
        end else if (btn_release || off_wake) begin
          state_next = SOWS_ST_RUN;
        end
      end
      SOWS_ST_MECHOFF: begin
        // Only network wake, the alarm or the button restart a cut supply
        if (btn_release || net_rise || alarm_hit) begin
          state_next = SOWS_ST_RUN;
        end
      end
      default: begin
        state_next = SOWS_ST_MECHOFF;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_reg <= SOWS_ST_MECHOFF;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // LED blink

  logic [CNT_W-1:0] blink_cnt_reg;
  logic             blink_reg;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      blink_cnt_reg <= '0;
      blink_reg     <= 1'b0;
    end else if (state_reg != SOWS_ST_SUSPEND) begin
      blink_cnt_reg <= '0;
      blink_reg     <= 1'b1;
    end else if (tick) begin
      if (blink_cnt_reg == CNT_W'(BLINK_TICKS - 1)) begin
        blink_cnt_reg <= '0;
        blink_reg     <= ~blink_reg;
      end else begin
        blink_cnt_reg <= blink_cnt_reg + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      power_led       <= 1'b0;
      supply_on       <= 1'b0;
      display_suspend <= 1'b1;
      disk_spin_down  <= 1'b1;
      cpu_running     <= 1'b0;
    end else begin
      case (state_reg)
        SOWS_ST_RUN:     power_led <= 1'b1;
        SOWS_ST_SUSPEND: power_led <= blink_reg;
        default:         power_led <= 1'b0;
      endcase
      supply_on       <= (state_reg != SOWS_ST_MECHOFF);
      display_suspend <= (state_reg != SOWS_ST_RUN);
      disk_spin_down  <= (state_reg == SOWS_ST_STBYOFF) ||
                         (state_reg == SOWS_ST_MECHOFF);
      cpu_running     <= (state_reg == SOWS_ST_RUN);
    end
  end

  assign power_state = state_reg;

  ////////////////////////////////////////////////////////////////////////
  // Event reporting

  logic [WAKE_SRC_N-1:0] cause_set;
  logic                  woke;

  assign woke = (state_next == SOWS_ST_RUN) && (state_reg != SOWS_ST_RUN);

  always_comb begin
    cause_set = '0;
    if (woke) begin
      cause_set[WK_BUTTON] = btn_release;
      cause_set[WK_RING]   = ring_rise;
      cause_set[WK_ALARM]  = alarm_hit;
      cause_set[WK_NET]    = net_rise;
    end
  end

  // Set wins over the acknowledge
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wake_cause <= '0;
    end else begin
      wake_cause <= (event_ack ? '0 : wake_cause) | cause_set;
    end
  end

  logic pending_reg;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pending_reg <= 1'b0;
    end else if (woke || (state_reg == SOWS_ST_RUN && btn_release)) begin
      pending_reg <= 1'b1;
    end else if (event_ack) begin
      pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      smi_out <= 1'b0;
      sci_out <= 1'b0;
    end else begin
      smi_out <= pending_reg && !sci_mode;
      sci_out <= pending_reg && sci_mode;
    end
  end

endmodule

// File: bench/sows_sequencer_properties.sv
`timescale 1ns/1ps
module sows_sequencer_checker
  import sows_pkg::*;
(
  input wire logic               sys_clk,
  input wire logic               reset,
  input wire logic               sci_mode,
  input wire logic               remote_network_wake,
  input wire logic               alarm_enable,
  input wire logic [ALARM_W-1:0] alarm_time,
  input wire logic [ALARM_W-1:0] rtc_time,
  input wire logic               power_led,
  input wire logic               supply_on,
  input wire logic               display_suspend,
  input wire logic               disk_spin_down,
  input wire logic               cpu_running,
  input wire logic               smi_out,
  input wire logic               sci_out,
  input wire logic [3:0]         wake_cause,
  input wire logic [3:0]         power_state
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  property p_run;
    power_state == 4'h1 [*2] |-> power_led && supply_on && cpu_running && !display_suspend;
  endproperty
  a_run: assert property (p_run) else $error("run outputs wrong");
  property p_susp;
    power_state == 4'h2 [*2] |-> !cpu_running;
  endproperty
  a_susp: assert property (p_susp) else $error("suspend still running");
  property p_stby;
    power_state == 4'h4 [*2] |-> display_suspend && disk_spin_down && !cpu_running;
  endproperty
  a_stby: assert property (p_stby) else $error("standby outputs wrong");
  property p_off;
    power_state == 4'h8 [*2] |-> !supply_on;
  endproperty
  a_off: assert property (p_off) else $error("supply on while off");
  property p_fell;
    $fell(supply_on) |-> power_state == 4'h8;
  endproperty
  a_fell: assert property (p_fell) else $error("supply dropped outside off");
  property p_hot;
    $onehot(power_state);
  endproperty
  a_hot: assert property (p_hot) else $error("state not one-hot");
  property p_net;
    $rose(remote_network_wake) && power_state == 4'h8 |-> ##[1:10] power_state == 4'h1;
  endproperty
  a_net: assert property (p_net) else $error("network wake ignored");
  property p_alarm;
    alarm_enable && alarm_time == rtc_time && power_state == 4'h8 |-> ##[1:8] power_state == 4'h1;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm wake ignored");
  property p_smi;
    sci_mode [*3] |-> !smi_out;
  endproperty
  a_smi: assert property (p_smi) else $error("smi in sci mode");
  property p_sci;
    !sci_mode [*3] |-> !sci_out;
  endproperty
  a_sci: assert property (p_sci) else $error("sci in smi mode");
  property p_rep;
    $rose(|wake_cause) |-> ##[0:4] (smi_out || sci_out);
  endproperty
  a_rep: assert property (p_rep) else $error("wake not reported");
endmodule

bind sows_sequencer sows_sequencer_checker sows_sequencer_checker_inst (
  .sys_clk, .reset, .sci_mode, .remote_network_wake, .alarm_enable, .alarm_time,
  .rtc_time, .power_led, .supply_on, .display_suspend, .disk_spin_down,
  .cpu_running, .smi_out, .sci_out, .wake_cause, .power_state
);

// File: bench/sows_far_side.sv
`timescale 1ns/1ps
// Button, wake sources and clock chip; fire bit 0 key, 1 suspend, 2 ring, 3 net
module sows_far_side (
  input  wire logic        sys_clk,
  input  wire logic [3:0]  fire,
  input  wire logic        button_down,
  output logic             power_button,
  output logic             keypress,
  output logic             suspend_request,
  output logic             modem_ring,
  output logic             remote_network_wake,
  output logic [31:0]      rtc_time
);
  logic [15:0] sh_reg = 16'h0;
  logic [3:0]  div_reg = 4'h0;
  // Button level is held by the bench, long enough to pass the debounce
  assign power_button = button_down;
  // Pulses last 4 cycles so the synchroniser cannot miss them
  assign {remote_network_wake, modem_ring, suspend_request, keypress} =
    {sh_reg[12], sh_reg[8], sh_reg[4], sh_reg[0]};
  always @(posedge sys_clk) begin
    for (int i = 0; i < 4; i++)
      sh_reg[i*4 +: 4] <= fire[i] ? 4'hF : (sh_reg[i*4 +: 4] >> 1);
    div_reg <= div_reg + 4'h1;
    if (div_reg == 4'hF) rtc_time <= rtc_time + 32'h1;
  end
  initial rtc_time = 32'h0;
endmodule

// File: bench/tb_sows_sequencer.sv
`timescale 1ns/1ps
module tb_sows_sequencer;
  import sows_pkg::*;
  logic sys_clk = 0, reset = 1, atx_present = 1, sci_mode = 0, alarm_enable = 0, event_ack = 0;
  logic button_down = 0;
  // Short tick so debounce, blink and the long hold fit in one run
  localparam int TB_TICK = 4;
  logic [31:0] alarm_time = 32'hFFFFFFFF, rtc_time;
  logic [3:0]  fire = 4'h0, wake_cause, power_state;
  logic power_button, keypress, modem_ring, remote_network_wake, suspend_request;
  logic power_led, supply_on, display_suspend, disk_spin_down, cpu_running, smi_out, sci_out;
  int errors = 0, n_tests = 0, seed = 8176;
  always #2.5 sys_clk = ~sys_clk;
  sows_far_side sows_far_side_inst (.sys_clk, .fire, .button_down, .power_button, .keypress,
    .suspend_request, .modem_ring, .remote_network_wake, .rtc_time);
  sows_sequencer #(.TICK_CYCLES(TB_TICK)) sows_sequencer_inst (.sys_clk, .reset,
    .atx_present, .power_button,
    .keypress, .modem_ring, .remote_network_wake, .suspend_request, .sci_mode,
    .alarm_enable, .alarm_time, .rtc_time, .event_ack, .power_led, .supply_on,
    .display_suspend, .disk_spin_down, .cpu_running, .smi_out, .sci_out,
    .wake_cause, .power_state);
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(string what, logic [3:0] exp, logic [3:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic pulse(int b);
    fire[b] <= 1'b1;
    @(posedge sys_clk) fire[b] <= 1'b0;
    repeat (12) @(posedge sys_clk);
  endtask
  // Bounded wait, then three more edges so the outputs settle
  task automatic wait_st(logic [3:0] exp, int lim);
    for (int i = 0; i < lim && power_state !== exp; i++) @(posedge sys_clk);
    repeat (3) @(posedge sys_clk);
    chk("state", exp, power_state);
  endtask
  // Press well past the debounce, then let go
  task automatic press(int n);
    button_down <= 1'b1;
    repeat (n) @(posedge sys_clk);
    button_down <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  // Cycles from press until the forced-off hold fires
  function automatic int hold_cycles();
    return TB_TICK * (DEBOUNCE_TICKS + HOLD_OFF_TICKS);
  endfunction
  task automatic ack();
    event_ack <= 1'b1;
    repeat (2) @(posedge sys_clk);
    event_ack <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic do_reset();
    reset <= 1'b1;
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    chk("supply", 4'h0, {3'h0, supply_on});
    pulse(3);
    wait_st(SOWS_ST_RUN, 40);
    chk("cause", 4'h8, wake_cause);
    chk("report", 4'h1, {3'h0, smi_out});
    $display("test net wake done");
    for (int k = 0; k < 6; k++) begin
      sci_mode <= $random(seed);
      ack();
      pulse(0);
      chk("key refused", SOWS_ST_RUN, power_state);
      pulse(1);
      wait_st(SOWS_ST_SUSPEND, 40);
      if (k == 0) begin
        chk("blink on", 4'h1, {3'h0, power_led});
        repeat (TB_TICK * BLINK_TICKS + 10) @(posedge sys_clk);
        chk("blink off", 4'h0, {3'h0, power_led});
      end
      pulse(k[0] ? 2 : 0);
      wait_st(SOWS_ST_RUN, 40);
      chk("led", 4'h1, {3'h0, power_led});
      chk("report", 4'h1, {3'h0, sci_mode ? sci_out : smi_out});
      if (k[0]) chk("cause", 4'h2, wake_cause & 4'h2);
      $display("test suspend cycle %0d done", k);
    end
    ack();
    press(80);
    wait_st(SOWS_ST_STBYOFF, 100);
    chk("supply", 4'h1, {3'h0, supply_on});
    chk("standby", 4'h3, {2'h0, display_suspend, disk_spin_down});
    pulse(2);
    wait_st(SOWS_ST_RUN, 40);
    chk("cause", 4'h2, wake_cause & 4'h2);
    press(80);
    wait_st(SOWS_ST_STBYOFF, 100);
    ack();
    press(80);
    wait_st(SOWS_ST_RUN, 100);
    chk("cause", 4'h1, wake_cause);
    button_down <= 1'b1;
    repeat (hold_cycles() - 40) @(posedge sys_clk);
    chk("hold early", SOWS_ST_RUN, power_state);
    repeat (80) @(posedge sys_clk);
    chk("hold", SOWS_ST_MECHOFF, power_state);
    button_down <= 1'b0;
    repeat (100) @(posedge sys_clk);
    chk("hold release", SOWS_ST_MECHOFF, power_state);
    chk("supply", 4'h0, {3'h0, supply_on});
    press(80);
    wait_st(SOWS_ST_RUN, 100);
    atx_present <= 1'b0;
    press(80);
    wait_st(SOWS_ST_MECHOFF, 100);
    atx_present <= 1'b1;
    $display("test button done");
    do_reset();
    pulse(2);
    chk("ring refused", SOWS_ST_MECHOFF, power_state);
    alarm_time <= rtc_time + 32'h2 + ($unsigned($random(seed)) % 4);
    alarm_enable <= 1'b1;
    wait_st(SOWS_ST_RUN, 400);
    chk("cause", 4'h4, wake_cause & 4'h4);
    $display("test alarm done");
    wrap_up();
  end
  initial begin
    #(5 * 40000);
    errors++;
    $display("[FAIL] watchdog expected end seen hang");
    wrap_up();
  end
endmodule
